// >>> usdp_consts.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * shadow data port.
 * Assumes a 50 MHz bus clock and a 32-bit classic Wishbone bus.
 */
`ifndef USDP_CONSTS_SVH
`define USDP_CONSTS_SVH

// Aliased data slots, sixteen word locations
`define USDP_SLOT_FIRST      32'h50001130
`define USDP_SLOT_LAST       32'h5000116c
`define USDP_SLOT2_ADDR      32'h50001138
`define USDP_SLOT3_ADDR      32'h5000113c
`define USDP_SLOT_RESET      16'h0000
// Control, status and bit period registers
`define USDP_CTRL_ADDR       32'h50001100
`define USDP_STAT_ADDR       32'h50001104
`define USDP_DIV_ADDR        32'h50001108
// Control fields
`define USDP_CTRL_FIFO_EN    0
`define USDP_CTRL_IR_MODE    1
// Status fields
`define USDP_STAT_DATA_VALID 0
`define USDP_STAT_OVERRUN    1
`define USDP_STAT_TX_EMPTY   5
`define USDP_STAT_TX_IDLE    6
`define USDP_STAT_RX_CNT_LSB 8
`define USDP_STAT_TX_CNT_LSB 16
// FIFO depth
`define USDP_FIFO_DEPTH      16
// Timing
`define USDP_CLK_HZ          50000000
`define USDP_BAUD_HZ         115200
`define USDP_DIV_RESET       16'(`USDP_CLK_HZ / `USDP_BAUD_HZ)

`endif

// >>> usdp_pkg.sv
/*
 * Types of the shadow data port: bus carriers and serial phases.
 * Assumes usdp_consts.svh for the numeric values.
 */
package usdp_pkg;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [31:0] adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} usdp_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} usdp_wb_rsp_t;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_START,
		PH_DATA,
		PH_STOP
	} usdp_phase_t;

endpackage : usdp_pkg

// >>> usdp_data_port.sv
/*
 * Shadow receive/transmit data port of a serial UART, with 8N1
 * receiver and transmitter, receive and transmit FIFOs and a
 * classic Wishbone slave.
 * Assumes one 50 MHz clock, synchronous active-high reset, and serial
 * inputs that are asynchronous to the clock.
 */
// Overview of operation
// [R1] All sixteen aliased data words behave identically for burst access.
// [R2] Reads give the received byte in bits 7:0, serial or infrared input.
// [R3] Software trusts read data only while the data valid flag is set.
// [R4] FIFOs off: new character overwrites unread byte and flags overrun.
// [R5] FIFOs on: a read returns the oldest receive FIFO entry.
// [R6] Full receive FIFO: keep contents, drop new character, flag overrun.
// [R7] Written byte goes out on serial output or active-low infrared output.
// [R8] Software writes only while the transmit holding empty flag is set.
// [R9] FIFOs off: one write clears the transmit holding empty flag.
// [R10] FIFOs off: further writes before empty replace the pending byte.
// [R11] FIFOs on: sixteen writes are accepted before the FIFO is full.
// [R12] Writes to a full transmit FIFO are discarded.
// [R13] Bits 15:8 read as zero and ignore writes.
`timescale 1ns/100ps
`include "usdp_consts.svh"

module usdp_data_port (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire usdp_pkg::usdp_wb_req_t wb_req_i,
	output usdp_pkg::usdp_wb_rsp_t      wb_rsp_o,
	input  wire logic                  rxd_i,
	input  wire logic                  ir_rxd_i,
	output logic                       txd_o,
	output logic                       ir_txd_n_o
);
	import usdp_pkg::*;

	typedef struct packed {
		logic              ack;
		logic [31:0]       rdata;
		logic              fifo_en;
		logic              ir_mode;
		logic [15:0]       div;
		logic [1:0]        s_rx;
		logic [1:0]        s_ir;
		logic [15:0][7:0]  rx_mem;
		logic [3:0]        rx_rd;
		logic [4:0]        rx_cnt;
		logic              overrun;
		usdp_phase_t       rx_ph;
		logic [15:0]       rx_tmr;
		logic [2:0]        rx_bit;
		logic [7:0]        rx_sh;
		logic [15:0][7:0]  tx_mem;
		logic [3:0]        tx_rd;
		logic [4:0]        tx_cnt;
		usdp_phase_t       tx_ph;
		logic [15:0]       tx_tmr;
		logic [2:0]        tx_bit;
		logic [7:0]        tx_sh;
		logic              txd;
		logic              tx_line;
		logic              ir_n;
	} usdp_state_t;

	usdp_state_t s;
	usdp_state_t next_s;

	// Any of the sixteen aliased data words
	function automatic logic is_slot(input logic [31:0] a);
		is_slot = (a >= `USDP_SLOT_FIRST) && (a <= `USDP_SLOT_LAST)
			&& (a[1:0] == 2'b00);
	endfunction : is_slot

	logic        req;
	logic        wr;
	logic        rd;
	logic        line;
	logic        rx_push;
	logic [3:0]  rx_wr;
	logic [3:0]  tx_wr;
	logic [31:0] stat;
	logic        hit_slot;
	logic        hit_ctrl;
	logic        hit_stat;
	logic        hit_div;

	always_comb begin
		next_s = s;
		req = wb_req_i.cyc && wb_req_i.stb && !s.ack;
		wr = req && wb_req_i.we;
		rd = req && !wb_req_i.we;
		rx_push = 1'b0;
		rx_wr = 4'h0;
		tx_wr = 4'h0;

		// Address decode
		hit_slot = 1'b0;
		hit_ctrl = 1'b0;
		hit_stat = 1'b0;
		hit_div = 1'b0;
		if (is_slot(wb_req_i.adr))
			hit_slot = 1'b1;
		else if (wb_req_i.adr == `USDP_CTRL_ADDR)
			hit_ctrl = 1'b1;
		else if (wb_req_i.adr == `USDP_STAT_ADDR)
			hit_stat = 1'b1;
		else if (wb_req_i.adr == `USDP_DIV_ADDR)
			hit_div = 1'b1;

		// Input synchronisers
		next_s.s_rx = {s.s_rx[0], rxd_i};
		next_s.s_ir = {s.s_ir[0], ir_rxd_i};
		// [R2] Input by mode
		line = s.ir_mode ? !s.s_ir[1] : s.s_rx[1];

		stat = 32'h0;
		stat[`USDP_STAT_DATA_VALID] = (s.rx_cnt != 5'h0);
		stat[`USDP_STAT_OVERRUN] = s.overrun;
		stat[`USDP_STAT_TX_EMPTY] = (s.tx_cnt == 5'h0);
		stat[`USDP_STAT_TX_IDLE] = (s.tx_cnt == 5'h0) && (s.tx_ph == PH_IDLE);
		stat[`USDP_STAT_RX_CNT_LSB +: 5] = s.rx_cnt;
		stat[`USDP_STAT_TX_CNT_LSB +: 5] = s.tx_cnt;

		// Bus answer, one cycle after the request
		next_s.ack = req;
		next_s.rdata = 32'h0;
		if (rd) begin
			// [R1] Same answer at every alias
			if (hit_slot) begin
				// [R13] Upper bits zero
				next_s.rdata = {24'h0, s.rx_mem[s.rx_rd]};
				// [R5] Pop the head
				if (s.rx_cnt != 5'h0) begin
					next_s.rx_rd = s.rx_rd + 4'h1;
					next_s.rx_cnt = s.rx_cnt - 5'h1;
				end
			end else if (hit_ctrl) begin
				next_s.rdata[`USDP_CTRL_FIFO_EN] = s.fifo_en;
				next_s.rdata[`USDP_CTRL_IR_MODE] = s.ir_mode;
			end else if (hit_stat) begin
				next_s.rdata = stat;
				next_s.overrun = 1'b0;
			end else if (hit_div) begin
				next_s.rdata = {16'h0, s.div};
			end
		end

		if (wr && hit_ctrl && wb_req_i.sel[0]) begin
			next_s.ir_mode = wb_req_i.dat[`USDP_CTRL_IR_MODE];
			next_s.fifo_en = wb_req_i.dat[`USDP_CTRL_FIFO_EN];
			// FIFO enable change flushes both queues
			if (wb_req_i.dat[`USDP_CTRL_FIFO_EN] != s.fifo_en) begin
				next_s.rx_cnt = 5'h0;
				next_s.tx_cnt = 5'h0;
			end
		end else if (wr && hit_div) begin
			if (wb_req_i.sel[0])
				next_s.div[7:0] = wb_req_i.dat[7:0];
			if (wb_req_i.sel[1])
				next_s.div[15:8] = wb_req_i.dat[15:8];
		end

		// Receiver
		case (s.rx_ph)
			PH_IDLE: begin
				if (!line) begin
					next_s.rx_ph = PH_START;
					next_s.rx_tmr = {1'b0, s.div[15:1]};
				end
			end
			PH_START: begin
				if (s.rx_tmr != 16'h0) begin
					next_s.rx_tmr = s.rx_tmr - 16'h1;
				end else if (!line) begin
					next_s.rx_ph = PH_DATA;
					next_s.rx_tmr = s.div - 16'h1;
					next_s.rx_bit = 3'h0;
				end else begin
					next_s.rx_ph = PH_IDLE;
				end
			end
			PH_DATA: begin
				if (s.rx_tmr != 16'h0) begin
					next_s.rx_tmr = s.rx_tmr - 16'h1;
				end else begin
					next_s.rx_sh = {line, s.rx_sh[7:1]};
					next_s.rx_tmr = s.div - 16'h1;
					next_s.rx_bit = s.rx_bit + 3'h1;
					if (s.rx_bit == 3'h7)
						next_s.rx_ph = PH_STOP;
				end
			end
			default: begin
				if (s.rx_tmr != 16'h0) begin
					next_s.rx_tmr = s.rx_tmr - 16'h1;
				end else begin
					next_s.rx_ph = PH_IDLE;
					rx_push = 1'b1;
				end
			end
		endcase

		if (rx_push) begin
			rx_wr = next_s.rx_rd + next_s.rx_cnt[3:0];
			if (s.fifo_en) begin
				// [R6] Full: drop and flag
				if (next_s.rx_cnt == 5'(`USDP_FIFO_DEPTH)) begin
					next_s.overrun = 1'b1;
				end else begin
					next_s.rx_mem[rx_wr] = s.rx_sh;
					next_s.rx_cnt = next_s.rx_cnt + 5'h1;
				end
			end else if (next_s.rx_cnt != 5'h0) begin
				// [R4] Overwrite unread byte
				next_s.rx_mem[next_s.rx_rd] = s.rx_sh;
				next_s.overrun = 1'b1;
			end else begin
				next_s.rx_mem[next_s.rx_rd] = s.rx_sh;
				next_s.rx_cnt = 5'h1;
			end
		end

		// [R7] Transmitter
		case (s.tx_ph)
			PH_IDLE: begin
				next_s.tx_line = 1'b1;
				if (s.tx_cnt != 5'h0) begin
					next_s.tx_sh = s.tx_mem[s.tx_rd];
					next_s.tx_rd = s.tx_rd + 4'h1;
					next_s.tx_cnt = next_s.tx_cnt - 5'h1;
					next_s.tx_ph = PH_START;
					next_s.tx_tmr = s.div - 16'h1;
					next_s.tx_line = 1'b0;
				end
			end
			PH_START: begin
				if (s.tx_tmr != 16'h0) begin
					next_s.tx_tmr = s.tx_tmr - 16'h1;
				end else begin
					next_s.tx_ph = PH_DATA;
					next_s.tx_tmr = s.div - 16'h1;
					next_s.tx_bit = 3'h0;
					next_s.tx_line = s.tx_sh[0];
				end
			end
			PH_DATA: begin
				if (s.tx_tmr != 16'h0) begin
					next_s.tx_tmr = s.tx_tmr - 16'h1;
				end else begin
					next_s.tx_tmr = s.div - 16'h1;
					next_s.tx_bit = s.tx_bit + 3'h1;
					if (s.tx_bit == 3'h7) begin
						next_s.tx_ph = PH_STOP;
						next_s.tx_line = 1'b1;
					end else begin
						next_s.tx_line = s.tx_sh[s.tx_bit + 3'h1];
					end
				end
			end
			default: begin
				if (s.tx_tmr != 16'h0)
					next_s.tx_tmr = s.tx_tmr - 16'h1;
				else
					next_s.tx_ph = PH_IDLE;
			end
		endcase

		// Transmit data write, low byte lane only
		if (wr && hit_slot && wb_req_i.sel[0]) begin
			tx_wr = next_s.tx_rd + next_s.tx_cnt[3:0];
			if (s.fifo_en) begin
				// [R11] [R12] Accept up to depth, else drop
				if (next_s.tx_cnt != 5'(`USDP_FIFO_DEPTH)) begin
					next_s.tx_mem[tx_wr] = wb_req_i.dat[7:0];
					next_s.tx_cnt = next_s.tx_cnt + 5'h1;
				end
			end else if (next_s.tx_cnt != 5'h0) begin
				// [R10] Replace pending byte
				next_s.tx_mem[next_s.tx_rd] = wb_req_i.dat[7:0];
			end else begin
				// [R9] Holding now full
				next_s.tx_mem[next_s.tx_rd] = wb_req_i.dat[7:0];
				next_s.tx_cnt = 5'h1;
			end
		end

		// [R7] Infrared output low on zero bits
		next_s.txd = s.ir_mode ? 1'b1 : next_s.tx_line;
		next_s.ir_n = s.ir_mode ? next_s.tx_line : 1'b1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.div <= `USDP_DIV_RESET;
			s.s_rx <= 2'b11;
			s.s_ir <= 2'b00;
			s.rx_ph <= PH_IDLE;
			s.tx_ph <= PH_IDLE;
			s.txd <= 1'b1;
			s.tx_line <= 1'b1;
			s.ir_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign wb_rsp_o.ack = s.ack;
	assign wb_rsp_o.dat = s.rdata;
	assign txd_o = s.txd;
	assign ir_txd_n_o = s.ir_n;

endmodule : usdp_data_port

// >>> usdp_sva.sv
/* Checker of the data port bus answer and line outputs.
   Assumes binding to usdp_data_port and a bit period above 2. */
`timescale 1ns/100ps
`include "usdp_consts.svh"
module usdp_sva (
	input wire logic                   clk_i,
	input wire logic                   rst_i,
	input wire usdp_pkg::usdp_wb_req_t wb_req_i,
	input wire usdp_pkg::usdp_wb_rsp_t wb_rsp_o,
	input wire logic                   rxd_i,
	input wire logic                   ir_rxd_i,
	input wire logic                   txd_o,
	input wire logic                   ir_txd_n_o
);
	import usdp_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic tk;
	logic slot;
	assign tk = wb_req_i.cyc & wb_req_i.stb & ~wb_rsp_o.ack;
	assign slot = wb_req_i.adr >= `USDP_SLOT_FIRST &&
		wb_req_i.adr <= `USDP_SLOT_LAST;
	property p_take; tk |=> wb_rsp_o.ack; endproperty
	a_take: assert property (p_take) else $error("no ack");
	property p_pulse; wb_rsp_o.ack |=> !wb_rsp_o.ack; endproperty
	a_pulse: assert property (p_pulse) else $error("long ack");
	property p_cause; wb_rsp_o.ack |-> $past(tk); endproperty
	a_cause: assert property (p_cause) else $error("stray ack");
	property p_upper;
		wb_rsp_o.ack && slot |-> wb_rsp_o.dat[31:8] == 24'h0;
	endproperty
	a_upper: assert property (p_upper) else $error("upper bits");
	property p_idle; !wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("data w/o ack");
	property p_excl; txd_o || ir_txd_n_o; endproperty
	a_excl: assert property (p_excl) else $error("both lines");
	property p_start; $fell(txd_o) |=> !txd_o [*2]; endproperty
	a_start: assert property (p_start) else $error("short start");
	property p_rst;
		$fell(rst_i) |-> txd_o && ir_txd_n_o && !wb_rsp_o.ack;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	c_wr: cover property (tk && wb_req_i.we && slot);
	c_rd: cover property (tk && !wb_req_i.we && slot);
	c_ir: cover property ($fell(ir_txd_n_o));
endmodule : usdp_sva
bind usdp_data_port usdp_sva usdp_sva_i (.clk_i(clk_i), .rst_i(rst_i),
	.wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .rxd_i(rxd_i),
	.ir_rxd_i(ir_rxd_i), .txd_o(txd_o), .ir_txd_n_o(ir_txd_n_o));

// >>> usdp_peer.sv
/* Remote serial peer: 8N1 sender and receiver, plain or infrared.
   Assumes BIT equals the port's bit period in clocks. */
`timescale 1ns/100ps
module usdp_peer #(
	parameter int BIT = 8
) (
	input  wire logic clk_i,
	input  wire logic txd_o,
	input  wire logic ir_txd_n_o,
	output logic      rxd_i,
	output logic      ir_rxd_i
);
	logic [7:0] got[$];
	logic [7:0] b;
	wire        ln = txd_o & ir_txd_n_o;
	initial begin
		rxd_i = 1'b1;
		ir_rxd_i = 1'b0;
	end
	task automatic send(input logic [7:0] d, input logic ir);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_i);
			rxd_i <= ir | f[i];
			ir_rxd_i <= ir & ~f[i];
			repeat (BIT - 1) @(posedge clk_i);
		end
	endtask : send
	initial forever begin
		@(negedge ln);
		repeat (BIT / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clk_i);
			b[i] = ln;
		end
		repeat (BIT) @(posedge clk_i);
		got.push_back(b);
	end
endmodule : usdp_peer

// >>> tb.sv
/* Testbench of the shadow data port against a serial peer.
   Assumes usdp_consts.svh and a bit period of 8 clocks. */
`timescale 1ns/100ps
`include "usdp_consts.svh"
module tb;
	import usdp_pkg::*;
	logic         clk_i = 1'b0;
	logic         rst_i = 1'b1;
	usdp_wb_req_t wb_req_i = '0;
	usdp_wb_rsp_t wb_rsp_o;
	logic         rxd_i;
	logic         ir_rxd_i;
	logic         txd_o;
	logic         ir_txd_n_o;
	logic [31:0]  q;
	int           err_total = 0;
	int           checks = 0;
	always #10 clk_i = ~clk_i;
	usdp_data_port usdp_data_port_i (.clk_i(clk_i), .rst_i(rst_i),
		.wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .rxd_i(rxd_i),
		.ir_rxd_i(ir_rxd_i), .txd_o(txd_o), .ir_txd_n_o(ir_txd_n_o));
	usdp_peer #(.BIT(8)) usdp_peer_i (.clk_i(clk_i), .txd_o(txd_o),
		.ir_txd_n_o(ir_txd_n_o), .rxd_i(rxd_i), .ir_rxd_i(ir_rxd_i));
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [31:0] a, d);
		int n;
		@(posedge clk_i);
		wb_req_i <= '{1'b1, 1'b1, w, a, 4'hf, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_rsp_o.ack !== 1'b1 && n < 50);
		q = wb_rsp_o.dat;
		wb_req_i <= '0;
		if (wb_rsp_o.ack !== 1'b1) begin
			err_total++;
			end_of_test();
		end
	endtask : wb
	task automatic wait_rx(input int n);
		int k;
		for (k = 0; k < 4000 && usdp_peer_i.got.size() < n; k++)
			@(posedge clk_i);
		if (usdp_peer_i.got.size() < n) begin
			err_total++;
			end_of_test();
		end
	endtask : wait_rx
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, `USDP_SLOT2_ADDR, 0);
		chk("slot2", 32'h0, q);
		wb(0, `USDP_STAT_ADDR, 0);
		chk("status", 32'h60, q);
		wb(0, 32'h50001200, 0);
		chk("unmapped", 32'h0, q);
		wb(1, `USDP_DIV_ADDR, 32'h8);
		wb(0, `USDP_DIV_ADDR, 0);
		chk("divisor", 32'h8, q);
		wb(1, `USDP_SLOT3_ADDR, 32'h1a5);
		wb(1, `USDP_SLOT2_ADDR, 32'h11);
		wb(0, `USDP_STAT_ADDR, 0);
		chk("holding empty", 32'h0, q & 32'h20);
		wb(1, `USDP_SLOT_LAST, 32'h22);
		wait_rx(2);
		chk("tx first", 32'ha5, {24'h0, usdp_peer_i.got[0]});
		chk("tx replaced", 32'h22, {24'h0, usdp_peer_i.got[1]});
		usdp_peer_i.got.delete();
		usdp_peer_i.send(8'h3c, 1'b0);
		usdp_peer_i.send(8'h5a, 1'b0);
		repeat (8) @(posedge clk_i);
		wb(0, `USDP_STAT_ADDR, 0);
		chk("overrun", 32'h3, q & 32'h3);
		wb(0, `USDP_SLOT_LAST, 0);
		chk("overwrite", 32'h5a, q);
		wb(0, `USDP_STAT_ADDR, 0);
		chk("drained", 32'h0, q & 32'h3);
		wb(1, `USDP_CTRL_ADDR, 32'h3);
		wb(0, `USDP_CTRL_ADDR, 0);
		chk("control", 32'h3, q);
		for (int i = 0; i < 17; i++)
			usdp_peer_i.send(8'h40 + 8'(i), 1'b1);
		repeat (8) @(posedge clk_i);
		wb(0, `USDP_STAT_ADDR, 0);
		chk("rx full", 32'h1003, q & 32'h1f03);
		for (int i = 0; i < 16; i++) begin
			wb(0, `USDP_SLOT_FIRST + 32'(4 * i), 0);
			chk("rx head", 32'h40 + 32'(i), q);
		end
		for (int i = 0; i < 18; i++)
			wb(1, `USDP_SLOT_FIRST + 32'(4 * (i % 16)), 32'h80 + 32'(i));
		wb(0, `USDP_STAT_ADDR, 0);
		chk("tx full", 32'h100000, q & 32'h1f0000);
		wait_rx(17);
		for (int i = 0; i < 17; i++)
			chk("tx fifo", 32'h80 + 32'(i), {24'h0, usdp_peer_i.got[i]});
		repeat (200) @(posedge clk_i);
		chk("tx dropped", 32'd17, 32'(usdp_peer_i.got.size()));
		end_of_test();
	end
endmodule : tb
